// >>> flash_status_pkg.sv
package flash_status_pkg;

   // Width of the status word and of the data bus.
   localparam int WORD_W = 8;
   localparam int DQ_W = 16;
   localparam int CMD_W = 8;

   // Status word bit positions.
   localparam int BIT_READY      = 7;
   localparam int BIT_ERS_SUSP   = 6;
   localparam int BIT_ERS_FAIL   = 5;
   localparam int BIT_PGM_FAIL   = 4;
   localparam int BIT_SUPPLY_LOW = 3;
   localparam int BIT_PGM_SUSP   = 2;
   localparam int BIT_LOCK_ABORT = 1;
   localparam int BIT_PART_BUSY  = 0;

   // Bits held per partition; bit 7 and bit 0 are derived live.
   localparam int FLAG_HI = 6;
   localparam int FLAG_LO = 1;

   // Upper data byte during a status read.
   localparam logic [DQ_W-WORD_W-1:0] UPPER_ZERO = 8'h00;

   // Mode-changing command codes.
   localparam logic [CMD_W-1:0] CMD_READ_ARRAY = 8'hff;
   localparam logic [CMD_W-1:0] CMD_READ_IDENT = 8'h90;

   // Idle level of the synchronised strobes and reset pin.
   localparam logic PIN_IDLE_HIGH = 1'b1;

   typedef enum logic [1:0] {
      MODE_ARRAY  = 2'b00,
      MODE_STATUS = 2'b01,
      MODE_IDENT  = 2'b10,
      MODE_QUERY  = 2'b11
   } mode_t;

endpackage

// >>> flash_status_report.sv
`timescale 1ns/1ps

module flash_status_report #(
   parameter int                NPART            = 8,
   parameter int                ADDR_W           = 21,
   parameter int                PART_ADDR_W      = 18,
   parameter logic [7:0]        CMD_READ_STATUS  = 8'h70,
   parameter logic [7:0]        CMD_CLEAR_STATUS = 8'h50,
   parameter logic [7:0]        CMD_READ_QUERY   = 8'h98,
   localparam int               PART_W           = $clog2(NPART)
) (
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire logic              dev_rst_n,
   input  wire logic              wp_n,
   input  wire logic              ce_n,
   input  wire logic              oe_n,
   input  wire logic              we_n,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [15:0]       dq_in,
   output logic      [15:0]       dq_out,
   output logic                   dq_oe,
   input  wire logic              engine_busy,
   input  wire logic [PART_W-1:0] busy_part,
   input  wire logic              seq_accept,
   input  wire logic [PART_W-1:0] accept_part,
   input  wire logic [PART_W-1:0] ev_part,
   input  wire logic              ev_erase_suspend,
   input  wire logic              ev_erase_resume,
   input  wire logic              ev_program_suspend,
   input  wire logic              ev_program_resume,
   input  wire logic              ev_erase_fail,
   input  wire logic              ev_program_fail,
   input  wire logic              ev_seq_error,
   input  wire logic              ev_supply_low,
   input  wire logic              ev_locked_target,
   input  wire logic              stream_active,
   input  wire logic              stream_word_busy,
   output logic                   cmd_valid,
   output logic [7:0]             cmd_code,
   output logic [15:0]            cmd_data,
   output logic [ADDR_W-1:0]      cmd_addr,
   output logic [NPART-1:0]       status_mode
);

   localparam int SYNC_W = 5 + ADDR_W + flash_status_pkg::DQ_W;

   localparam logic [SYNC_W-1:0] SYNC_RESET =
      {{5{flash_status_pkg::PIN_IDLE_HIGH}}, {(SYNC_W-5){1'b0}}};

   typedef logic [flash_status_pkg::FLAG_HI:flash_status_pkg::FLAG_LO] flags_t;

   typedef struct packed {
      flash_status_pkg::mode_t [NPART-1:0] mode;
      flags_t [NPART-1:0]                  flags;
      logic                                ce_n_q;
      logic                                oe_n_q;
      logic                                we_n_q;
      logic [flash_status_pkg::WORD_W-1:0] word;
      logic                                drive;
      logic                                cmd_valid;
      logic [flash_status_pkg::CMD_W-1:0]  cmd_code;
      logic [flash_status_pkg::DQ_W-1:0]   cmd_data;
      logic [ADDR_W-1:0]                   cmd_addr;
   } state_t;

   state_t st;
   state_t next_st;

   logic [SYNC_W-1:0] pins_raw;
   logic [SYNC_W-1:0] pins_s;

   logic              dev_rst_n_s;
   logic              wp_n_s;
   logic              ce_n_s;
   logic              oe_n_s;
   logic              we_n_s;
   logic [ADDR_W-1:0] addr_s;
   logic [15:0]       dq_s;

   logic              wr_ev;
   logic              capture_ev;
   logic              read_low;
   logic              status_sel;
   logic [PART_W-1:0] sel_part;

   assign pins_raw = {dev_rst_n, wp_n, ce_n, oe_n, we_n, addr, dq_in};

   pin_sync #(
      .W         (SYNC_W),
      .RESET_VAL (SYNC_RESET)
   ) u_pin_sync (
      .ref_clk (ref_clk),
      .rst     (rst),
      .d       (pins_raw),
      .q       (pins_s)
   );

   assign {dev_rst_n_s, wp_n_s, ce_n_s, oe_n_s, we_n_s, addr_s, dq_s} = pins_s;

   // Partition index taken from the address lines above one partition.
   function automatic logic [PART_W-1:0] part_of(input logic [ADDR_W-1:0] a);
      part_of = a[PART_ADDR_W +: PART_W];
   endfunction

   // Builds the word one partition presents on a status read.
   function automatic logic [flash_status_pkg::WORD_W-1:0] status_word(
      input state_t            s,
      input logic [PART_W-1:0] p
   );
      logic [flash_status_pkg::WORD_W-1:0] w;
      w = '0;
      w[flash_status_pkg::BIT_READY] = !engine_busy;
      w[flash_status_pkg::FLAG_HI:flash_status_pkg::FLAG_LO] = s.flags[p];
      // Bit 0 is only set while bit 7 reads busy, so the two are never both high.
      if (engine_busy && stream_active)
      begin
         w[flash_status_pkg::BIT_PART_BUSY] = stream_word_busy;
      end
      else if (engine_busy)
      begin
         w[flash_status_pkg::BIT_PART_BUSY] = (busy_part != p);
      end
      else
      begin
         w[flash_status_pkg::BIT_PART_BUSY] = 1'b0;
      end
      status_word = w;
   endfunction

   // Read mode that a command code selects; any other code keeps the current mode.
   function automatic flash_status_pkg::mode_t mode_of_cmd(
      input logic [flash_status_pkg::CMD_W-1:0] code,
      input flash_status_pkg::mode_t           cur
   );
      flash_status_pkg::mode_t m;
      m = cur;
      if (code == CMD_READ_STATUS)
      begin
         m = flash_status_pkg::MODE_STATUS;
      end
      else if (code == flash_status_pkg::CMD_READ_ARRAY)
      begin
         m = flash_status_pkg::MODE_ARRAY;
      end
      else if (code == flash_status_pkg::CMD_READ_IDENT)
      begin
         m = flash_status_pkg::MODE_IDENT;
      end
      else if (code == CMD_READ_QUERY)
      begin
         m = flash_status_pkg::MODE_QUERY;
      end
      mode_of_cmd = m;
   endfunction

   // Applies one cycle of engine pulses to the stored bits of one partition.
   // Sets come after the clears so that an event in a clear cycle survives.
   function automatic flags_t engine_update(
      input flags_t f,
      input logic   hit
   );
      flags_t r;
      r = f;
      if (hit)
      begin
         // Resumes clear suspend bits; they are the only bits the engine clears.
         if (ev_erase_resume)
         begin
            r[flash_status_pkg::BIT_ERS_SUSP] = 1'b0;
         end
         if (ev_program_resume)
         begin
            r[flash_status_pkg::BIT_PGM_SUSP] = 1'b0;
         end
         if (ev_erase_suspend)
         begin
            r[flash_status_pkg::BIT_ERS_SUSP] = 1'b1;
         end
         if (ev_program_suspend)
         begin
            r[flash_status_pkg::BIT_PGM_SUSP] = 1'b1;
         end
         if (ev_erase_fail)
         begin
            r[flash_status_pkg::BIT_ERS_FAIL] = 1'b1;
         end
         if (ev_program_fail)
         begin
            r[flash_status_pkg::BIT_PGM_FAIL] = 1'b1;
         end
         if (ev_seq_error)
         begin
            r[flash_status_pkg::BIT_ERS_FAIL] = 1'b1;
            r[flash_status_pkg::BIT_PGM_FAIL] = 1'b1;
         end
         if (ev_supply_low)
         begin
            r[flash_status_pkg::BIT_SUPPLY_LOW] = 1'b1;
         end
         if (ev_locked_target && !wp_n_s)
         begin
            r[flash_status_pkg::BIT_LOCK_ABORT] = 1'b1;
         end
      end
      engine_update = r;
   endfunction

   // A command write is taken when the write strobe rises under chip select.
   assign wr_ev = st.we_n_q == 1'b0 && we_n_s == 1'b1 && ce_n_s == 1'b0;

   // Only the first of the two read strobes to fall latches a new word.
   assign capture_ev = st.ce_n_q && st.oe_n_q && (!ce_n_s || !oe_n_s);

   assign read_low = !ce_n_s && !oe_n_s;

   assign sel_part = part_of(addr_s);

   // Stream programming turns every read into a status read.
   assign status_sel = stream_active
      || st.mode[sel_part] == flash_status_pkg::MODE_STATUS;

   // Next state: strobe history, command decode, engine pulses and status capture.
   always_comb
   begin
      next_st = st;
      next_st.ce_n_q = ce_n_s;
      next_st.oe_n_q = oe_n_s;
      next_st.we_n_q = we_n_s;
      next_st.cmd_valid = 1'b0;

      if (wr_ev)
      begin
         next_st.cmd_valid = 1'b1;
         next_st.cmd_code = dq_s[flash_status_pkg::CMD_W-1:0];
         next_st.cmd_data = dq_s;
         next_st.cmd_addr = addr_s;
      end

      // Writes during stream programming are data, not commands.
      if (wr_ev && !stream_active)
      begin
         if (dq_s[flash_status_pkg::CMD_W-1:0] == CMD_CLEAR_STATUS)
         begin
            // Clear acts on the stored bits only, never on the mode.
            next_st.flags[sel_part] = '0;
         end
         next_st.mode[sel_part] = mode_of_cmd(dq_s[flash_status_pkg::CMD_W-1:0],
                                              st.mode[sel_part]);
      end

      if (seq_accept)
      begin
         next_st.mode[accept_part] = flash_status_pkg::MODE_STATUS;
      end

      // Every partition sees the engine pulses; only the one named by ev_part
      // takes them, after any clear-status above so that the set wins.
      for (int i = 0; i < NPART; i++)
      begin
         next_st.flags[i] = engine_update(next_st.flags[i], ev_part == PART_W'(i));
      end

      if (capture_ev && status_sel)
      begin
         next_st.word = status_word(st, sel_part);
      end

      // Drive only while a single status read is under way.
      next_st.drive = read_low && status_sel;

      if (!dev_rst_n_s)
      begin
         next_st.flags = '0;
         for (int i = 0; i < NPART; i++)
         begin
            next_st.mode[i] = flash_status_pkg::MODE_ARRAY;
         end
         next_st.word = '0;
         next_st.drive = 1'b0;
         next_st.cmd_valid = 1'b0;
      end
   end

   // Strobe history resets to the idle level so no false edge follows reset.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         st <= '0;
         st.ce_n_q <= flash_status_pkg::PIN_IDLE_HIGH;
         st.oe_n_q <= flash_status_pkg::PIN_IDLE_HIGH;
         st.we_n_q <= flash_status_pkg::PIN_IDLE_HIGH;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign dq_out = {flash_status_pkg::UPPER_ZERO, st.word};
   assign dq_oe = st.drive;
   assign cmd_valid = st.cmd_valid;
   assign cmd_code = st.cmd_code;
   assign cmd_data = st.cmd_data;
   assign cmd_addr = st.cmd_addr;

   // One read-status flag per partition for the engine side.
   always_comb
   begin
      for (int i = 0; i < NPART; i++)
      begin
         status_mode[i] = st.mode[i] == flash_status_pkg::MODE_STATUS;
      end
   end

endmodule // flash_status_report

// >>> flash_status_report_checker.sv
`timescale 1ns/1ps

module flash_status_report_checker #(
   parameter int         ADDR_W          = 21,
   parameter int         NPART           = 8,
   parameter int         PART_ADDR_W     = 18,
   parameter logic [7:0] CMD_READ_STATUS = 8'h70,
   localparam int        PW              = $clog2(NPART)
) (
   input wire logic              ref_clk,
   input wire logic              rst,
   input wire logic              dev_rst_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [15:0]       dq_out,
   input wire logic              dq_oe,
   input wire logic              engine_busy,
   input wire logic [PW-1:0]     busy_part,
   input wire logic              seq_accept,
   input wire logic [PW-1:0]     accept_part,
   input wire logic              stream_active,
   input wire logic              stream_word_busy,
   input wire logic              cmd_valid,
   input wire logic [7:0]        cmd_code,
   input wire logic [ADDR_W-1:0] cmd_addr,
   input wire logic [NPART-1:0]  status_mode
);
   logic [PW-1:0] cp;
   logic [PW-1:0] rp;
   assign cp = cmd_addr[PART_ADDR_W +: PW];
   assign rp = addr[PART_ADDR_W +: PW];

   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   AST_UPPER_ZERO: assert property (dq_oe |-> dq_out[15:8] == 8'h00)
      else $error("upper byte not zero");
   AST_RS_MODE: assert property (cmd_valid && cmd_code == CMD_READ_STATUS && !stream_active
      |-> status_mode[cp]) else $error("read-status did not enter mode");
   AST_ARRAY_MODE: assert property (cmd_valid && !stream_active
      && cmd_code == flash_status_pkg::CMD_READ_ARRAY |-> !status_mode[cp])
      else $error("read-array left status mode on");
   AST_OTHERS: assert property (cmd_valid
      |-> ((status_mode ^ $past(status_mode)) & ~(NPART'(1) << cp)) == '0)
      else $error("other partition mode changed");
   AST_ACCEPT: assert property (seq_accept |=> status_mode[$past(accept_part)])
      else $error("accepted sequence not in status mode");
   AST_READY: assert property ($rose(dq_oe) && !stream_active && $stable(engine_busy)
      |-> dq_out[7] == !engine_busy) else $error("ready bit wrong");
   AST_PART_BUSY: assert property ($rose(dq_oe) && !stream_active
      && $stable({engine_busy, busy_part}) |-> dq_out[0] == (engine_busy && busy_part != rp))
      else $error("partition busy bit wrong");
   AST_NEVER_BOTH: assert property (dq_oe |-> !(dq_out[7] && dq_out[0]))
      else $error("bits 7 and 0 both set");
   AST_STREAM_WORD: assert property ($rose(dq_oe) && stream_active
      && $stable({stream_word_busy, engine_busy})
      |-> dq_out[0] == (stream_word_busy && engine_busy)) else $error("stream word bit wrong");
   AST_DEV_RESET: assert property (!dev_rst_n [*5] |-> status_mode == '0 && !dq_oe)
      else $error("device reset did not clear");

   cover property (cmd_valid && cmd_code == CMD_READ_STATUS);
   cover property ($rose(dq_oe) && stream_active);
   cover property (seq_accept);
endmodule // flash_status_report_checker

bind flash_status_report flash_status_report_checker #(
   .ADDR_W(ADDR_W),
   .NPART(NPART),
   .PART_ADDR_W(PART_ADDR_W),
   .CMD_READ_STATUS(CMD_READ_STATUS)
) flash_status_report_checker_inst (
   .ref_clk, .rst, .dev_rst_n, .addr, .dq_out, .dq_oe, .engine_busy, .busy_part,
   .seq_accept, .accept_part, .stream_active, .stream_word_busy, .cmd_valid, .cmd_code,
   .cmd_addr, .status_mode
);

// >>> host_bus.sv
`timescale 1ns/1ps

module host_bus #(
   parameter int ADDR_W = 21
) (
   input  wire logic         ref_clk,
   input  wire logic [15:0]  dq_out,
   input  wire logic         dq_oe,
   output logic              ce_n = 1'b1,
   output logic              oe_n = 1'b1,
   output logic              we_n = 1'b1,
   output logic [ADDR_W-1:0] addr = '0,
   output logic [15:0]       dq_in = 16'h5a5a
);
   task automatic wr(input logic [2:0] p, input logic [7:0] code);
      @(negedge ref_clk);
      addr = ADDR_W'({p, 18'h00000});
      dq_in = {8'h00, code};
      ce_n = 1'b0;
      we_n = 1'b0;
      repeat (4) @(negedge ref_clk);
      we_n = 1'b1;
      repeat (4) @(negedge ref_clk);
      ce_n = 1'b1;
      dq_in = ~dq_in;
      repeat (3) @(negedge ref_clk);
   endtask

   // One single read per strobe pulse, never a burst.
   task automatic rd(input logic [2:0] p, output logic [15:0] w, output logic seen);
      int n;
      n = 0;
      seen = 1'b0;
      @(negedge ref_clk);
      addr = ADDR_W'({p, 18'h00000});
      ce_n = 1'b0;
      oe_n = 1'b0;
      while (!seen && n < 8)
      begin
         @(negedge ref_clk);
         seen = (dq_oe === 1'b1);
         n++;
      end
      w = dq_out;
      oe_n = 1'b1;
      ce_n = 1'b1;
      repeat (6) @(negedge ref_clk);
   endtask
endmodule // host_bus

// >>> pin_sync.sv
`timescale 1ns/1ps

module pin_sync #(
   parameter int             W         = 1,
   parameter logic [W-1:0]   RESET_VAL = '0
) (
   input  wire logic         ref_clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sync_state_t;

   sync_state_t st;
   sync_state_t next_st;

   // The first stage feeds only the second stage.
   always_comb
   begin
      next_st        = st;
      next_st.meta   = d;
      next_st.stable = st.meta;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         st <= {RESET_VAL, RESET_VAL};
      end
      else
      begin
         st <= next_st;
      end
   end

   assign q = st.stable;

endmodule // pin_sync

// >>> tb.sv
`timescale 1ns/1ps

module tb;
   typedef struct packed {
      logic [3:0] ev;
      logic [2:0] p;
      logic       wp;
      logic       busy;
      logic [2:0] bp;
      logic [7:0] want;
   } row_t;

   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        dev_rst_n = 1'b1;
   logic        wp_n = 1'b1;
   logic        ce_n, oe_n, we_n, dq_oe, seen;
   logic [20:0] addr;
   logic [15:0] dq_in, dq_out, rw;
   logic        engine_busy = 1'b0;
   logic [2:0]  busy_part = 3'h0;
   logic [2:0]  accept_part = 3'h0;
   logic [2:0]  ev_part = 3'h0;
   logic        seq_accept = 1'b0;
   logic        stream_active = 1'b0;
   logic        stream_word_busy = 1'b0;
   logic [15:0] cmd_word;
   logic [8:0]  ev = 9'h000;
   logic [7:0]  status_mode;
   int          fail_count = 0;
   int          n_compared = 0;
   // Event index: 0..3 suspend/resume, 4..8 the error events, f none.
   row_t        rows [10] = '{
      '{4'hf, 3'h0, 1'b1, 1'b1, 3'h0, 8'h00},
      '{4'hf, 3'h0, 1'b1, 1'b1, 3'h3, 8'h01},
      '{4'h4, 3'h1, 1'b1, 1'b0, 3'h0, 8'ha0},
      '{4'h5, 3'h2, 1'b1, 1'b0, 3'h0, 8'h90},
      '{4'h6, 3'h3, 1'b1, 1'b0, 3'h0, 8'hb0},
      '{4'h7, 3'h4, 1'b1, 1'b0, 3'h0, 8'h88},
      '{4'h8, 3'h5, 1'b0, 1'b0, 3'h0, 8'h82},
      '{4'h8, 3'h5, 1'b1, 1'b0, 3'h0, 8'h80},
      '{4'h0, 3'h6, 1'b1, 1'b0, 3'h0, 8'hc0},
      '{4'h2, 3'h7, 1'b1, 1'b0, 3'h0, 8'h84}};

   always #25 ref_clk = ~ref_clk;

   flash_status_report flash_status_report_inst (
      .ref_clk, .rst, .dev_rst_n, .wp_n, .ce_n, .oe_n, .we_n, .addr, .dq_in, .dq_out,
      .dq_oe, .engine_busy, .busy_part, .seq_accept, .accept_part, .ev_part,
      .ev_erase_suspend(ev[0]), .ev_erase_resume(ev[1]), .ev_program_suspend(ev[2]),
      .ev_program_resume(ev[3]), .ev_erase_fail(ev[4]), .ev_program_fail(ev[5]),
      .ev_seq_error(ev[6]), .ev_supply_low(ev[7]), .ev_locked_target(ev[8]),
      .stream_active, .stream_word_busy, .cmd_valid(), .cmd_code(),
      .cmd_data(cmd_word), .cmd_addr(),
      .status_mode);
   host_bus host_bus_inst (.ref_clk, .dq_out, .dq_oe, .ce_n, .oe_n, .we_n, .addr, .dq_in);

   task automatic chk(input logic [15:0] a, input logic [15:0] b);
      n_compared++;
      if (a !== b)
      begin
         fail_count++;
         $display("ERROR %0t: saw %h want %h", $time, a, b);
      end
   endtask

   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic pulse(input logic [3:0] idx, input logic [2:0] p);
      @(negedge ref_clk);
      ev_part = p;
      if (idx < 4'h9)
         ev[idx] = 1'b1;
      @(negedge ref_clk);
      ev = 9'h000;
   endtask

   task automatic rd_chk(input logic [2:0] p, input logic [7:0] want);
      host_bus_inst.rd(p, rw, seen);
      chk(seen === 1'b1 ? rw : 16'hxxxx, {8'h00, want});
   endtask

   initial
   begin
      repeat (4) @(negedge ref_clk);
      rst = 1'b0;
      repeat (4) @(negedge ref_clk);
      chk({7'h00, dq_oe, status_mode}, 16'h0000);
      $display("test done: reset");
      foreach (rows[i])
      begin
         wp_n = rows[i].wp;
         engine_busy = rows[i].busy;
         busy_part = rows[i].bp;
         host_bus_inst.wr(rows[i].p, 8'h70);
         pulse(rows[i].ev, rows[i].p);
         rd_chk(rows[i].p, rows[i].want);
         host_bus_inst.wr(rows[i].p, 8'h50);
         rd_chk(rows[i].p, {~rows[i].busy, 6'h00, rows[i].busy && rows[i].bp != rows[i].p});
         $display("test done: row %0d", i);
      end
      pulse(4'h5, 3'h1);
      pulse(4'h0, 3'h1);
      pulse(4'h1, 3'h1);
      pulse(4'h3, 3'h1);
      host_bus_inst.wr(3'h1, 8'hff);
      host_bus_inst.wr(3'h1, 8'h70);
      rd_chk(3'h1, 8'h90);
      host_bus_inst.wr(3'h1, 8'h50);
      host_bus_inst.wr(3'h2, 8'hff);
      chk({8'h00, status_mode}, 16'h00fb);
      host_bus_inst.rd(3'h2, rw, seen);
      chk({15'h0000, seen}, 16'h0000);
      $display("test done: sticky");
      accept_part = 3'h2;
      seq_accept = 1'b1;
      @(negedge ref_clk);
      seq_accept = 1'b0;
      @(negedge ref_clk);
      chk({8'h00, status_mode}, 16'h00ff);
      stream_active = 1'b1;
      engine_busy = 1'b1;
      stream_word_busy = 1'b1;
      rd_chk(3'h2, 8'h01);
      stream_word_busy = 1'b0;
      host_bus_inst.wr(3'h2, 8'hff);
      chk({8'h00, status_mode}, 16'h00ff);
      chk(cmd_word, 16'h00ff);
      rd_chk(3'h2, 8'h00);
      engine_busy = 1'b0;
      stream_word_busy = 1'b1;
      rd_chk(3'h2, 8'h80);
      stream_active = 1'b0;
      stream_word_busy = 1'b0;
      rd_chk(3'h2, 8'h80);
      $display("test done: stream");
      host_bus_inst.wr(3'h3, 8'h90);
      host_bus_inst.wr(3'h4, 8'h98);
      chk({8'h00, status_mode}, 16'h00e7);
      $display("test done: other modes");
      pulse(4'h4, 3'h6);
      dev_rst_n = 1'b0;
      repeat (6) @(negedge ref_clk);
      dev_rst_n = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk({8'h00, status_mode}, 16'h0000);
      host_bus_inst.wr(3'h6, 8'h70);
      rd_chk(3'h6, 8'h80);
      $display("test done: device reset");
      end_sim();
   end

   initial
   begin
      #400000;
      fail_count++;
      $display("ERROR %0t: watchdog expired", $time);
      end_sim();
   end
endmodule // tb
